// ===== rtl/dclca_pkg.sv
`default_nettype none
package dclca_pkg;

    // timing of one integration cycle at the system clock rate
    localparam int CLK_PERIOD_NS = 100;
    localparam int CYCLE_TIME_NS = 2700000;
    localparam int CYCLE_CLKS = CYCLE_TIME_NS / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ITIME = 8'h04;
    localparam logic [7:0] OFS_THRESH = 8'h08;
    localparam logic [7:0] OFS_PERSIST = 8'h0c;
    localparam logic [7:0] OFS_DATA = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;

    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int STAT_ALERT_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_W = 2;

    // values after reset
    localparam logic CTRL_EN_RST = 1'b0;
    localparam logic [7:0] ITIME_RST = 8'h01;
    localparam logic [15:0] THR_LO_RST = 16'h0000;
    localparam logic [15:0] THR_HI_RST = 16'hffff;
    localparam logic [3:0] PERSIST_RST = 4'h0;
    localparam logic [STAT_W-1:0] MASK_RST = 2'h0;
    localparam logic [15:0] COUNT_MAX = 16'hffff;

    typedef struct packed {
        logic [15:0] ch1;
        logic [15:0] ch0;
    } dclca_result_t;

    typedef struct packed {
        logic [15:0] hi;
        logic [15:0] lo;
    } dclca_thr_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_INTEG = 2'b10
    } dclca_state_t;

    // saturating count step
    function automatic logic [15:0] dclca_sat_inc(input logic [15:0] v);
        dclca_sat_inc = (v == COUNT_MAX) ? v : v + 16'h0001;
    endfunction

endpackage
`default_nettype wire

// ===== rtl/dclca_conv.sv
`timescale 1ns/100ps
`default_nettype none
module dclca_conv import dclca_pkg::*; #(
    parameter int CYC_CLKS = CYCLE_CLKS,
    parameter int CNT_W = 15
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic [7:0] itime,
    output logic start_ff,
    output logic done_ff
);
    localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(CYC_CLKS - 1);

    dclca_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] tick_ff, nxt_tick;
    logic [7:0] ncyc_ff, nxt_ncyc;
    logic nxt_start, nxt_done;
    logic [7:0] target;

    // a count of zero is run as a single cycle
    assign target = (itime == 8'h00) ? 8'h01 : itime;

    always_comb begin
        nxt_state = state_ff;
        nxt_tick = tick_ff;
        nxt_ncyc = ncyc_ff;
        nxt_start = 1'b0;
        nxt_done = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (enable) begin
                    nxt_state = ST_INTEG;
                    nxt_start = 1'b1;
                    nxt_tick = '0;
                    nxt_ncyc = 8'h00;
                end
            end
            ST_INTEG: begin
                if (!enable) begin
                    nxt_state = ST_IDLE;
                end else if (tick_ff == TICK_LAST) begin
                    nxt_tick = '0;
                    if (ncyc_ff == target - 8'h01) begin
                        nxt_done = 1'b1;
                        nxt_start = 1'b1;
                        nxt_ncyc = 8'h00;
                    end else begin
                        nxt_ncyc = ncyc_ff + 8'h01;
                    end
                end else begin
                    nxt_tick = tick_ff + CNT_W'(1);
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            tick_ff <= '0;
            ncyc_ff <= 8'h00;
            start_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            tick_ff <= nxt_tick;
            ncyc_ff <= nxt_ncyc;
            start_ff <= nxt_start;
            done_ff <= nxt_done;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_done_restarts: assert property (done_ff |-> start_ff)
        else $error("conversion end without restart");
    a_done_after_tick: assert property (
        done_ff |-> $past(tick_ff) == TICK_LAST && $past(enable))
        else $error("conversion end off the cycle boundary");
    a_disable_stops: assert property (
        !enable ##1 !enable |-> !done_ff)
        else $error("conversion ended while disabled");
endmodule
`default_nettype wire

// ===== rtl/dclca_alert.sv
`timescale 1ns/100ps
`default_nettype none
module dclca_alert import dclca_pkg::*; (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic eval,
    input wire logic [15:0] value,
    input wire dclca_thr_t thr,
    input wire logic [3:0] persist,
    output logic raise_ff
);
    logic [3:0] cnt_ff, nxt_cnt;
    logic nxt_raise;
    logic oor;
    logic [3:0] need;

    assign oor = (value > thr.hi) || (value < thr.lo);
    assign need = (persist == 4'h0) ? 4'h1 : persist;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_raise = 1'b0;
        if (eval) begin
            if (oor) begin
                nxt_cnt = (cnt_ff == 4'hf) ? cnt_ff : cnt_ff + 4'h1;
                nxt_raise = (nxt_cnt >= need);
            end else begin
                nxt_cnt = 4'h0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= 4'h0;
            raise_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            raise_ff <= nxt_raise;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_raise_cause: assert property (
        raise_ff |-> $past(eval) && $past(oor))
        else $error("alert raised without out-of-range result");
    a_persist_met: assert property (raise_ff |-> cnt_ff >= need)
        else $error("alert raised before persistence met");
    a_inrange_clears: assert property (
        eval && !oor |=> cnt_ff == 4'h0 && !raise_ff)
        else $error("in-range result did not clear persistence");
endmodule
`default_nettype wire

// ===== rtl/dclca_top.sv
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - both channels integrate together, starting and ending in one cycle
// - at completion broadband goes to channel zero, infrared to one
// - results are double buffered; a read never mixes two conversions
// - next integration starts at once after transfer, while enabled
// - each result is an unsigned 16-bit count
// - all registers reached only through the one host bus port
// - alert when the channel zero result is above upper or below lower threshold
// - out-of-range must persist for the programmed count of results
// - alert is a level that stays set until firmware clears it
// - integration time is a programmed count of fixed-length cycles
module dclca_top import dclca_pkg::*; #(
    parameter int CYCLE_CLKS_P = CYCLE_CLKS,
    parameter int CNT_W = 15
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic adc0_pulse,
    input wire logic adc1_pulse,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata_ff,
    output logic hreadyout_ff,
    output logic hresp_ff,
    output logic irq_ff
);

    // ------------------------------------------------------------
    // front-end pulse synchronisers
    // ------------------------------------------------------------
    logic [2:0] a0_sync_ff, nxt_a0_sync;
    logic [2:0] a1_sync_ff, nxt_a1_sync;
    logic edge0;
    logic edge1;

    always_comb begin
        nxt_a0_sync = {a0_sync_ff[1:0], adc0_pulse};
        nxt_a1_sync = {a1_sync_ff[1:0], adc1_pulse};
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            a0_sync_ff <= 3'h0;
            a1_sync_ff <= 3'h0;
        end else begin
            a0_sync_ff <= nxt_a0_sync;
            a1_sync_ff <= nxt_a1_sync;
        end
    end

    // only the second and third stages are looked at
    assign edge0 = a0_sync_ff[1] & ~a0_sync_ff[2];
    assign edge1 = a1_sync_ff[1] & ~a1_sync_ff[2];

    // ------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------
    logic addr_ph;
    logic wr_pend_ff, nxt_wr_pend;
    logic [7:0] wr_addr_ff, nxt_wr_addr;
    logic [31:0] nxt_rdata;
    logic [31:0] rd_word;
    logic wr_ctrl;
    logic wr_itime;
    logic wr_thresh;
    logic wr_persist;
    logic wr_status;
    logic wr_mask;

    assign addr_ph = hsel && hready && htrans[1];

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    logic en_ff, nxt_en;
    logic [7:0] itime_ff, nxt_itime;
    dclca_thr_t thr_ff, nxt_thr;
    logic [3:0] persist_ff, nxt_persist;
    logic [STAT_W-1:0] status_ff, nxt_status;
    logic [STAT_W-1:0] mask_ff, nxt_mask;
    logic [STAT_W-1:0] w1c;
    logic [STAT_W-1:0] evt;
    logic nxt_irq;

    // ------------------------------------------------------------
    // conversion datapath
    // ------------------------------------------------------------
    logic conv_start;
    logic conv_done;
    logic alert_raise;
    logic [15:0] acc0_ff, nxt_acc0;
    logic [15:0] acc1_ff, nxt_acc1;
    dclca_result_t result_ff, nxt_result;

    dclca_conv #(
        .CYC_CLKS(CYCLE_CLKS_P),
        .CNT_W(CNT_W)
    ) u_conv (
        .mclk(mclk),
        .rstn(rstn),
        .enable(en_ff),
        .itime(itime_ff),
        .start_ff(conv_start),
        .done_ff(conv_done)
    );

    dclca_alert u_alert (
        .mclk(mclk),
        .rstn(rstn),
        .eval(conv_done),
        .value(acc0_ff),
        .thr(thr_ff),
        .persist(persist_ff),
        .raise_ff(alert_raise)
    );

    // both integrators share the start strobe from the cycle timer
    always_comb begin
        nxt_acc0 = acc0_ff;
        nxt_acc1 = acc1_ff;
        if (conv_start) begin
            nxt_acc0 = edge0 ? 16'h0001 : 16'h0000;
            nxt_acc1 = edge1 ? 16'h0001 : 16'h0000;
        end else if (en_ff) begin
            if (edge0) begin
                nxt_acc0 = dclca_sat_inc(acc0_ff);
            end
            if (edge1) begin
                nxt_acc1 = dclca_sat_inc(acc1_ff);
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            acc0_ff <= 16'h0000;
            acc1_ff <= 16'h0000;
        end else begin
            acc0_ff <= nxt_acc0;
            acc1_ff <= nxt_acc1;
        end
    end

    // both halves load on the same edge and only there
    always_comb begin
        nxt_result = result_ff;
        if (conv_done) begin
            nxt_result.ch0 = acc0_ff;
            nxt_result.ch1 = acc1_ff;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            result_ff <= '0;
        end else begin
            result_ff <= nxt_result;
        end
    end

    // ------------------------------------------------------------
    // bus slave: zero wait states, always OKAY
    // ------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        case (haddr[7:0])
            OFS_CTRL: rd_word[CTRL_EN_BIT] = en_ff;
            OFS_ITIME: rd_word[7:0] = itime_ff;
            OFS_THRESH: rd_word = thr_ff;
            OFS_PERSIST: rd_word[3:0] = persist_ff;
            OFS_DATA: rd_word = result_ff;
            OFS_STATUS: rd_word[STAT_W-1:0] = status_ff;
            OFS_MASK: rd_word[STAT_W-1:0] = mask_ff;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        nxt_wr_pend = addr_ph && hwrite;
        nxt_wr_addr = addr_ph ? haddr[7:0] : wr_addr_ff;
        nxt_rdata = hrdata_ff;
        if (addr_ph && !hwrite) begin
            nxt_rdata = rd_word;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata_ff <= 32'h0000_0000;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end else begin
            wr_pend_ff <= nxt_wr_pend;
            wr_addr_ff <= nxt_wr_addr;
            hrdata_ff <= nxt_rdata;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end
    end

    // data-phase write strobes
    assign wr_ctrl = wr_pend_ff && (wr_addr_ff == OFS_CTRL);
    assign wr_itime = wr_pend_ff && (wr_addr_ff == OFS_ITIME);
    assign wr_thresh = wr_pend_ff && (wr_addr_ff == OFS_THRESH);
    assign wr_persist = wr_pend_ff && (wr_addr_ff == OFS_PERSIST);
    assign wr_status = wr_pend_ff && (wr_addr_ff == OFS_STATUS);
    assign wr_mask = wr_pend_ff && (wr_addr_ff == OFS_MASK);

    // ------------------------------------------------------------
    // register updates
    // ------------------------------------------------------------
    always_comb begin
        nxt_en = wr_ctrl ? hwdata[CTRL_EN_BIT] : en_ff;
        nxt_itime = wr_itime ? hwdata[7:0] : itime_ff;
        nxt_thr = wr_thresh ? hwdata : thr_ff;
        nxt_persist = wr_persist ? hwdata[3:0] : persist_ff;
        nxt_mask = wr_mask ? hwdata[STAT_W-1:0] : mask_ff;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            en_ff <= CTRL_EN_RST;
            itime_ff <= ITIME_RST;
            thr_ff <= {THR_HI_RST, THR_LO_RST};
            persist_ff <= PERSIST_RST;
            mask_ff <= MASK_RST;
        end else begin
            en_ff <= nxt_en;
            itime_ff <= nxt_itime;
            thr_ff <= nxt_thr;
            persist_ff <= nxt_persist;
            mask_ff <= nxt_mask;
        end
    end

    // ------------------------------------------------------------
    // sticky status and interrupt; a new event beats the clear
    // ------------------------------------------------------------
    always_comb begin
        w1c = wr_status ? hwdata[STAT_W-1:0] : '0;
        evt = '0;
        evt[STAT_ALERT_BIT] = alert_raise;
        evt[STAT_DONE_BIT] = conv_done;
        nxt_status = (status_ff & ~w1c) | evt;
        nxt_irq = |(status_ff & mask_ff);
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            status_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            irq_ff <= nxt_irq;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_conv_end;
        conv_done;
    endsequence

    sequence s_results_loaded;
        result_ff.ch0 == $past(acc0_ff) && result_ff.ch1 == $past(acc1_ff);
    endsequence

    a_result_load: assert property (s_conv_end |=> s_results_loaded)
        else $error("results not loaded at conversion end");

    a_result_hold: assert property (!conv_done |=> $stable(result_ff))
        else $error("results changed between conversions");

    a_alert_set: assert property (
        alert_raise |=> status_ff[STAT_ALERT_BIT])
        else $error("raised alert not recorded");

    a_alert_sticky: assert property (
        status_ff[STAT_ALERT_BIT] && !w1c[STAT_ALERT_BIT]
        |=> status_ff[STAT_ALERT_BIT])
        else $error("alert dropped without a clear");

    a_irq_level: assert property (
        (|(status_ff & mask_ff)) [*2] |-> irq_ff)
        else $error("interrupt low while unmasked status set");

    a_bus_okay: assert property (hreadyout_ff && !hresp_ff)
        else $error("bus answer not ready or not okay");

    a_conv_restart: assert property (
        conv_done && en_ff |=> acc0_ff <= 16'h0001 && acc1_ff <= 16'h0001)
        else $error("integrators not restarted after transfer");

    sequence s_data_read;
        addr_ph && !hwrite && haddr[7:0] == OFS_DATA;
    endsequence

    sequence s_done_clear;
        wr_status && hwdata[STAT_DONE_BIT] && !conv_done;
    endsequence

    a_done_flag: assert property (
        s_conv_end |=> status_ff[STAT_DONE_BIT])
        else $error("finished conversion not flagged");

    a_done_w1c: assert property (
        s_done_clear |=> !status_ff[STAT_DONE_BIT])
        else $error("done flag not cleared by write of one");

    a_irq_track: assert property (
        irq_ff == $past(|(status_ff & mask_ff)))
        else $error("interrupt does not follow unmasked status");

    a_data_atomic: assert property (
        s_data_read |=> hrdata_ff == $past(result_ff))
        else $error("result read not taken from one conversion");

    a_rdata_hold: assert property (
        !(addr_ph && !hwrite) |=> $stable(hrdata_ff))
        else $error("read data changed without a read");

    a_en_lands: assert property (
        wr_ctrl |=> en_ff == $past(hwdata[CTRL_EN_BIT]))
        else $error("enable write did not land");

    a_itime_lands: assert property (
        wr_itime |=> itime_ff == $past(hwdata[7:0]))
        else $error("cycle count write did not land");

    a_thr_lands: assert property (
        wr_thresh |=> thr_ff == $past(hwdata))
        else $error("threshold write did not land");

    a_count_step: assert property (
        en_ff && !conv_start && edge0 && acc0_ff != COUNT_MAX
        |=> acc0_ff == $past(acc0_ff) + 16'h0001)
        else $error("broadband count did not step");

    a_count_sat: assert property (
        acc1_ff == COUNT_MAX && !conv_start |=> acc1_ff == COUNT_MAX)
        else $error("infrared count did not saturate");

endmodule
`default_nettype wire

// ===== dv/dclca_front_model.sv
`timescale 1ns/100ps
`default_nettype none
// light front end: counted pulse bursts on both channels at once
module dclca_front_model (
    input wire logic mclk,
    input wire logic go,
    input wire logic [7:0] n0,
    input wire logic [7:0] n1,
    output logic adc0_pulse,
    output logic adc1_pulse
);
    int i;
    initial begin
        adc0_pulse = 1'b0;
        adc1_pulse = 1'b0;
        forever begin
            do @(posedge mclk); while (go !== 1'b1);
            // two clocks high, two low: above the sync minimum
            for (i = 0; i < 256; i++) begin
                if (i >= n0 && i >= n1) break;
                adc0_pulse <= (i < n0);
                adc1_pulse <= (i < n1);
                repeat (2) @(posedge mclk);
                adc0_pulse <= 1'b0;
                adc1_pulse <= 1'b0;
                repeat (2) @(posedge mclk);
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/test_dual_channel_light_conversion_alert.sv
`timescale 1ns/100ps
`default_nettype none
module test_dual_channel_light_conversion_alert import dclca_pkg::*;;
    localparam int CYC = 20;
    logic mclk, rstn, hsel, hwrite, go;
    logic [31:0] haddr, hwdata, hrdata_ff, rd;
    logic [1:0] htrans;
    logic adc0_pulse, adc1_pulse, hreadyout_ff, hresp_ff, irq_ff;
    logic [7:0] n0, n1;
    int fail_count, n_compared, cyc;

    dclca_front_model u_front (.mclk(mclk), .go(go), .n0(n0), .n1(n1),
        .adc0_pulse(adc0_pulse), .adc1_pulse(adc1_pulse));
    dclca_top #(.CYCLE_CLKS_P(CYC), .CNT_W(5)) u_dut (.mclk(mclk),
        .rstn(rstn), .adc0_pulse(adc0_pulse), .adc1_pulse(adc1_pulse),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_ff),
        .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff),
        .hresp_ff(hresp_ff), .irq_ff(irq_ff));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // one single AHB transfer; caller stands just after a rising edge
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge mclk); while (hreadyout_ff !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout_ff !== 1'b1);
        r = hrdata_ff;
        chk("hresp", 32'h0, {31'h0, hresp_ff});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input string nm);
        ahb(1'b0, a, 32'h0, rd);
        chk(nm, e, rd);
    endtask

    task automatic burst(input logic [7:0] a, input logic [7:0] b);
        n0 <= a;
        n1 <= b;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
    endtask

    // poll until a conversion finishes, then clear its done flag
    task automatic wait_done();
        int k;
        rd = 32'h0;
        for (k = 0; k < 100 && rd[STAT_DONE_BIT] !== 1'b1; k++)
            ahb(1'b0, OFS_STATUS, 32'h0, rd);
        chk("done", 32'h1, {31'h0, rd[STAT_DONE_BIT]});
        wr(OFS_STATUS, 32'h00000002);
    endtask

    task automatic wait_irq(input logic lvl, output int t);
        int k;
        for (k = 0; k < 200; k++) begin
            @(posedge mclk);
            if (irq_ff === lvl) break;
        end
        t = cyc;
        chk("irq wait", {31'h0, lvl}, {31'h0, irq_ff});
    endtask

    task automatic t_reset();
        logic [7:0] ofs [8];
        logic [31:0] exp [8];
        int k;
        ofs = '{OFS_CTRL, OFS_ITIME, OFS_THRESH, OFS_PERSIST, OFS_DATA,
                OFS_STATUS, OFS_MASK, 8'h1c};
        exp = '{32'h0, 32'h1, 32'hffff0000, 32'h0, 32'h0, 32'h0, 32'h0,
                32'h0};
        for (k = 0; k < 8; k++) rchk(ofs[k], exp[k], "reset value");
        wr(8'h1c, 32'hffffffff);
        rchk(8'h1c, 32'h0, "unmapped");
        wr(OFS_DATA, 32'h12345678);
        rchk(OFS_DATA, 32'h0, "data read only");
        chk("irq reset", 32'h0, {31'h0, irq_ff});
        $display("test reset done");
    endtask

    task automatic t_convert();
        wr(OFS_ITIME, 32'h4);
        wr(OFS_CTRL, 32'h1);
        burst(8'h07, 8'h03);
        wait_done();
        rchk(OFS_DATA, 32'h00030007, "both chans");
        burst(8'h00, 8'h0c);
        wait_done();
        rchk(OFS_DATA, 32'h000c0000, "next result");
        wait_done();
        rchk(OFS_DATA, 32'h0, "cleared count");
        wr(OFS_CTRL, 32'h0);
        $display("test convert done");
    endtask

    task automatic t_period();
        logic [7:0] it [2];
        int e [2];
        int k, t0, t1;
        it = '{8'h00, 8'h03};
        e = '{CYC, 3 * CYC};
        for (k = 0; k < 2; k++) begin
            wr(OFS_STATUS, 32'h3);
            wr(OFS_ITIME, {24'h0, it[k]});
            wr(OFS_MASK, 32'h2);
            wr(OFS_CTRL, 32'h1);
            wait_irq(1'b1, t0);
            wr(OFS_STATUS, 32'h2);
            wait_irq(1'b0, t1);
            wait_irq(1'b1, t1);
            chk("period", e[k], t1 - t0);
            wr(OFS_CTRL, 32'h0);
            wr(OFS_STATUS, 32'h2);
            wr(OFS_MASK, 32'h0);
        end
        $display("test period done");
    endtask

    task automatic t_alert();
        wr(OFS_STATUS, 32'h3);
        wr(OFS_THRESH, 32'h00080002);
        wr(OFS_PERSIST, 32'h2);
        wr(OFS_ITIME, 32'h4);
        wr(OFS_MASK, 32'h1);
        wr(OFS_CTRL, 32'h1);
        burst(8'h05, 8'h0c);
        wait_done();
        rchk(OFS_STATUS, 32'h0, "ch1 ignored");
        burst(8'h0a, 8'h00);
        wait_done();
        rchk(OFS_STATUS, 32'h0, "one high");
        wait_done();
        rchk(OFS_STATUS, 32'h1, "then low");
        wr(OFS_CTRL, 32'h0);
        repeat (8) @(posedge mclk);
        chk("irq held", 32'h1, {31'h0, irq_ff});
        wr(OFS_MASK, 32'h0);
        repeat (2) @(posedge mclk);
        chk("irq masked", 32'h0, {31'h0, irq_ff});
        wr(OFS_MASK, 32'h1);
        repeat (2) @(posedge mclk);
        chk("irq unmasked", 32'h1, {31'h0, irq_ff});
        wr(OFS_STATUS, 32'h1);
        repeat (2) @(posedge mclk);
        chk("irq cleared", 32'h0, {31'h0, irq_ff});
        rchk(OFS_STATUS, 32'h0, "status cleared");
        $display("test alert done");
    endtask

    initial begin
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        go = 1'b0;
        n0 = 8'h00;
        n1 = 8'h00;
        fail_count = 0;
        n_compared = 0;
        cyc = 0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_convert();
        t_period();
        t_alert();
        conclude();
    end

    initial begin
        #3000000;
        fail_count++;
        $display("MISMATCH watchdog expected finish seen timeout");
        conclude();
    end
endmodule
`default_nettype wire
